/* logic/actree_pkg.sv */
// Purpose: shared constants and types for the converter clock tree block
// Assumes: 32-bit apb data, one word per register
// Notes:   offsets and field layouts used by the apb slave and its bench
package actree_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFS      = 8'h00;
    localparam logic [7:0] STATUS_OFFS    = 8'h04;
    localparam logic [7:0] SAMPLE_OFFS    = 8'h08;

    // control field positions
    localparam int CTRL_PMODE_LSB  = 0;   // 2 bits power mode
    localparam int CTRL_MDIV_LSB   = 2;   // 2 bits modulator divider
    localparam int CTRL_ODIV_LSB   = 4;   // 2 bits output clock divider
    localparam int CTRL_CSRC_LSB   = 6;   // 2 bits clock source
    localparam int CTRL_SWCTL_BIT  = 8;   // copied to the channels only; sw_ctl_pin_i selects register control

    // reset values
    localparam logic [8:0] CTRL_RESET = 9'h000;

    // divider ratios in master clock cycles
    localparam int MDIV_FAST_RATIO = 4;
    localparam int MDIV_MED_RATIO  = 8;
    localparam int MDIV_LOW_RATIO  = 32;

    // sixteen bit two's complement code limits
    localparam logic [15:0] CODE_MOST_NEG = 16'h8000;
    localparam logic [15:0] CODE_MOST_POS = 16'h7fff;

    typedef enum logic [1:0] {
        PM_LOW, PM_MEDIAN, PM_FAST, PM_RSVD
    } actree_pmode_e;

    typedef enum logic [1:0] {
        MD_DIV4, MD_DIV8, MD_DIV32, MD_RSVD
    } actree_mdiv_e;

    typedef enum logic [1:0] {
        CS_CMOS, CS_CRYSTAL, CS_LVDS, CS_RSVD
    } actree_csrc_e;

    // settings that travel together to every channel
    typedef struct packed {
        logic          sw_ctl;
        actree_csrc_e  clk_src;
        logic [1:0]    output_clk_divider;
        actree_mdiv_e  mod_div;
        actree_pmode_e pmode;
    } actree_cfg_s;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } actree_apb_req_s;

endpackage : actree_pkg

/* logic/actree_top.sv */
// Purpose: clock tree and power scaling control for an eight channel
//          sigma-delta converter: source select, modulator and output
//          data clock enables, global power mode
// Assumes: sys_clk_i is the master clock; derived clocks are enables
// Notes:   settings change only at a modulator/output period boundary
//
// What this block does
// - master clock comes from cmos, crystal or differential source
// - all converter cores use one shared master clock
// - modulator and output clocks derive from the master clock
// - modulator samples twice per modulator clock period
// - modulator divider offers only divide by 4, 8 and 32
// - power mode is fast, median or low, set apart from divider
// - divider and power mode apply to all channels together
// - results are 16-bit two's complement codes
// - output data clock runs continuously at master/2 for divider 0 or 1, else /4 or /8
// - strapped mode ties divider to power mode: 32, 8, 4
// - register mode makes mode and both dividers programmable
`timescale 1ns/1ps
module actree_top (
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      sw_ctl_pin_i,
    input  wire logic [1:0]                strap_pmode_i,
    input  wire logic                      strap_crystal_i,
    input  wire logic [15:0]               sample_code_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    output actree_pkg::actree_cfg_s        chan_cfg_o,
    output logic      [7:0]                chan_mod_en_o,
    output logic      [7:0]                chan_sample_en_o,
    output logic                           output_data_clk_o,
    output logic      [15:0]               result_code_o
);
    import actree_pkg::*;

    // software control register
    logic [8:0]  ctrl_reg;
    logic [15:0] code_reg;
    actree_cfg_s sw_cfg;
    actree_cfg_s req_cfg;
    actree_cfg_s act_reg;
    actree_cfg_s act_next;
    logic [4:0]  mcnt_reg;
    logic [2:0]  ocnt_reg;
    logic        oclk_reg;
    logic        mod_en_reg;
    logic        samp_en_reg;

    // apb decode
    wire         acc_w    = psel_i & penable_i;
    wire         hit_ctrl = (paddr_i == CTRL_OFFS);
    wire         hit_stat = (paddr_i == STATUS_OFFS);
    wire         hit_samp = (paddr_i == SAMPLE_OFFS);
    wire         mapped   = hit_ctrl | hit_stat | hit_samp;
    wire         wr_ctrl  = acc_w & pwrite_i & hit_ctrl;
    wire         bad_mdiv = (pwdata_i[CTRL_MDIV_LSB +: 2] == MD_RSVD);
    wire         bad_pm   = (pwdata_i[CTRL_PMODE_LSB +: 2] == PM_RSVD);
    wire         bad_cs   = (pwdata_i[CTRL_CSRC_LSB +: 2] == CS_RSVD);
    wire         wr_bad   = wr_ctrl & (bad_mdiv | bad_pm | bad_cs);

    assign pready_o  = 1'b1;
    assign pslverr_o = acc_w & (~mapped | wr_bad | (pwrite_i & ~hit_ctrl));

    // writes with reserved codes are refused, register keeps old value
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl && !wr_bad) begin
            ctrl_reg <= pwdata_i[8:0];
        end
    end

    // read data mux, registered
    wire [31:0] rd_mux =
        hit_ctrl ? {23'h000000, ctrl_reg} :
        hit_stat ? {23'h000000, act_reg} :
        hit_samp ? {16'h0000, code_reg} : 32'h00000000;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    // requested configuration: register or strapped pins
    assign sw_cfg = actree_cfg_s'(ctrl_reg);
    always_comb begin
        req_cfg = sw_cfg;
        if (!sw_ctl_pin_i) begin
            req_cfg.sw_ctl  = 1'b0;
            req_cfg.clk_src = strap_crystal_i ? CS_CRYSTAL : CS_CMOS;
            req_cfg.output_clk_divider = 2'h0;
            case (strap_pmode_i)
                2'h0:    req_cfg.pmode = PM_LOW;
                2'h1:    req_cfg.pmode = PM_MEDIAN;
                default: req_cfg.pmode = PM_FAST;
            endcase
            case (req_cfg.pmode)
                PM_LOW:    req_cfg.mod_div = MD_DIV32;
                PM_MEDIAN: req_cfg.mod_div = MD_DIV8;
                default:   req_cfg.mod_div = MD_DIV4;
            endcase
        end
    end

    // modulator period in master clocks, minus one
    wire [4:0] mlast =
        (act_reg.mod_div == MD_DIV32) ? 5'(MDIV_LOW_RATIO - 1) :
        (act_reg.mod_div == MD_DIV8)  ? 5'(MDIV_MED_RATIO - 1) :
                                        5'(MDIV_FAST_RATIO - 1);
    wire [2:0] olast  = 3'((1 << act_reg.output_clk_divider) - 1);
    wire       m_wrap = (mcnt_reg == mlast);
    wire       o_wrap = (ocnt_reg == olast);
    wire       m_half = (mcnt_reg == (mlast >> 1));
    // new settings only land where both counters wrap together
    wire       swap   = m_wrap & o_wrap;
    assign act_next   = swap ? req_cfg : act_reg;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            act_reg <= actree_cfg_s'(CTRL_RESET);
        end else begin
            act_reg <= act_next;
        end
    end

    // divider counters run from the master clock only
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            mcnt_reg    <= 5'h00;
            ocnt_reg    <= 3'h0;
            mod_en_reg  <= 1'b0;
            samp_en_reg <= 1'b0;
        end else begin
            mcnt_reg    <= m_wrap ? 5'h00 : mcnt_reg + 5'h01;
            ocnt_reg    <= o_wrap ? 3'h0 : ocnt_reg + 3'h1;
            mod_en_reg  <= m_wrap;
            samp_en_reg <= m_wrap | m_half;
        end
    end

    // output data clock: high in first half of each output period
    wire oclk_next = (act_next.output_clk_divider == 2'h0) ? ~oclk_reg :
                     (o_wrap ? 1'b1 : (ocnt_reg + 3'h1 > (olast >> 1))
                      ? 1'b0 : oclk_reg);
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            oclk_reg <= 1'b0;
        end else begin
            oclk_reg <= oclk_next;
        end
    end
    assign output_data_clk_o = oclk_reg;

    // result code, captured each modulator period
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            code_reg <= 16'h0000;
        end else if (m_wrap) begin
            code_reg <= sample_code_i;
        end
    end

    // one shared enable fans out to all eight channels
    assign chan_mod_en_o    = {8{mod_en_reg}};
    assign chan_sample_en_o = {8{samp_en_reg}};
    assign chan_cfg_o       = act_reg;
    assign result_code_o    = code_reg;

    // assertions
    property p_div_legal;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        act_reg.mod_div != MD_RSVD;
    endproperty
    a_div_legal: assert property (p_div_legal)
        else $error("illegal modulator divider active");

    property p_strap_track;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (swap && !sw_ctl_pin_i && strap_pmode_i == 2'h0) |=>
        act_reg.mod_div == MD_DIV32;
    endproperty
    a_strap_track: assert property (p_strap_track)
        else $error("strapped low power not at divide by 32");

    property p_two_samples;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mod_en_reg |-> samp_en_reg;
    endproperty
    a_two_samples: assert property (p_two_samples)
        else $error("sample enable missing on modulator edge");

    property p_fast_period;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (mod_en_reg && act_reg.mod_div == MD_DIV4 && $stable(act_reg))
        |-> ##4 mod_en_reg;
    endproperty
    a_fast_period: assert property (p_fast_period)
        else $error("divide by four period wrong");

    property p_no_midswap;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !swap |=> $stable(act_reg);
    endproperty
    a_no_midswap: assert property (p_no_midswap)
        else $error("settings changed mid period");

    property p_div1_toggle;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        // a swap away from divide by one restarts the clock high instead
        (act_reg.output_clk_divider == 2'h0 && $stable(act_reg) &&
         act_next.output_clk_divider == 2'h0)
        |=> oclk_reg != $past(oclk_reg);
    endproperty
    a_div1_toggle: assert property (p_div1_toggle)
        else $error("output clock not toggling at divide by one");

    property p_code_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !m_wrap |=> $stable(code_reg);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("result code changed off the period edge");

    property p_bad_write;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_bad |=> ctrl_reg == $past(ctrl_reg);
    endproperty
    a_bad_write: assert property (p_bad_write)
        else $error("reserved write altered control register");

    c_div32: cover property (@(posedge sys_clk_i)
        act_reg.mod_div == MD_DIV32 && mod_en_reg);
    c_lvds: cover property (@(posedge sys_clk_i) act_reg.clk_src == CS_LVDS);
    c_swap: cover property (@(posedge sys_clk_i)
        swap && req_cfg != act_reg);

endmodule : actree_top

/* bench/actree_code_src.sv */
// Purpose: far side sample source feeding the modulator code input
// Assumes: bench master clock stays in the range of the chosen mode
// Notes:   the code moves only at a modulator period boundary
`timescale 1ns/1ps
module actree_code_src (
    input  wire logic        sys_clk_i,
    input  wire logic        mod_en_i,
    input  wire logic [15:0] code_i,
    output logic      [15:0] sample_code_o = 16'h0000
);
    // next code is taken once per modulator period
    always @(posedge sys_clk_i) begin
        if (mod_en_i === 1'b1) begin
            sample_code_o <= code_i;
        end
    end
endmodule : actree_code_src

/* bench/tb_top.sv */
// Purpose: self-checking bench for the converter clock tree block
// Assumes: new settings land within 32 master cycles
// Notes:   apb expectations queue up and a bus monitor checks them
`timescale 1ns/1ps
module tb_top;
    import actree_pkg::*;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } actree_note_s;
    localparam int MR[3] = '{MDIV_FAST_RATIO, MDIV_MED_RATIO, MDIV_LOW_RATIO};
    localparam logic [8:0] BAD[3] = '{9'h003, 9'h00c, 9'h0c0};
    logic         sys_clk_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic         sw = 1'b1;
    logic [1:0]   spm = 2'h0;
    logic         sxt = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [15:0]  code = 16'h0000;
    logic [15:0]  scode;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    actree_cfg_s  cfg;
    logic [7:0]   men;
    logic [7:0]   sen;
    logic         data_clk;
    logic         dprev = 1'b0;
    logic [15:0]  res;
    logic [15:0]  cexp;
    logic [8:0]   v;
    logic [31:0]  rnd = 32'h73dbbae6;
    int           errors = 0;
    int           samples_checked = 0;
    int           mcnt = 0, mper = 0, scnt = 0, sper = 0, dcnt = 0, dper = 0;
    actree_note_s notes[$];

    actree_top dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .sw_ctl_pin_i(sw), .strap_pmode_i(spm), .strap_crystal_i(sxt),
        .sample_code_i(scode), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .chan_cfg_o(cfg), .chan_mod_en_o(men), .chan_sample_en_o(sen),
        .output_data_clk_o(data_clk), .result_code_o(res));
    actree_code_src src_u (.sys_clk_i(sys_clk_i), .mod_en_i(men[0]),
        .code_i(code), .sample_code_o(scode));

    // 25 mhz master clock
    always #20 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic complete_run;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic ok, input string s);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, s);
        end
    endtask : chk

    // one apb transfer, its expected answer noted first
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        int n;
        notes.push_back('{d, m, e});
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, "apb wait");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // periods measured by the monitor after settling
    task automatic per(input int m, input int d);
        repeat (100) @(posedge sys_clk_i);
        chk(mper == m, "modulator period");
        chk(sper == 2, "samples per period");
        if (d > 1) chk(dper == d, "data clock period");
    endtask : per

    // period counters and the apb answer checker
    always @(posedge sys_clk_i) begin
        actree_note_s n;
        mcnt <= mcnt + 1;
        dcnt <= dcnt + 1;
        dprev <= data_clk;
        scnt <= (men[0] === 1'b1) ? 0 : scnt + int'(sen[0]);
        if (men[0] === 1'b1) begin
            mper <= mcnt + 1;
            mcnt <= 0;
            sper <= scnt + int'(sen[0]);
        end
        if (data_clk === 1'b1 && dprev === 1'b0) begin
            dper <= dcnt + 1;
            dcnt <= 0;
        end
        if (reset_n_i) chk(men === {8{men[0]}}, "channels apart");
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            chk((prdata & n.m) === (n.d & n.m) && pslverr === n.e,
                "apb answer");
        end
    end

    // watchdog
    initial begin
        #800000;
        errors++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        apb(1'b0, CTRL_OFFS, 32'h0, 32'h1ff, 1'b0);
        apb(1'b0, STATUS_OFFS, 32'h0, 32'h0ff, 1'b0);
        for (int i = 0; i < 3; i++) begin
            for (int o = 0; o < 4; o++) begin
                // power mode never below what the divider's rate needs
                v = {1'b0, 2'(i), 2'(o), 2'(i), 2'(2 - o % (i + 1))};
                apb(1'b1, CTRL_OFFS, 32'(v), 32'h0, 1'b0);
                per(MR[i], 1 << o);
                apb(1'b0, STATUS_OFFS, 32'(v), 32'h0ff, 1'b0);
            end
        end
        // reserved codes and bad addresses are refused
        for (int k = 0; k < 3; k++) apb(1'b1, CTRL_OFFS, 32'(v | BAD[k]),
                                        32'h0, 1'b1);
        apb(1'b1, STATUS_OFFS, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
        apb(1'b0, CTRL_OFFS, 32'(v), 32'h0ff, 1'b0);
        // extreme and random codes pass to the result
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            cexp = (i == 0) ? CODE_MOST_NEG : (i == 1) ? CODE_MOST_POS
                                                       : rnd[15:0];
            code <= cexp;
            repeat (100) @(posedge sys_clk_i);
            chk(res === cexp, "result code");
            apb(1'b0, SAMPLE_OFFS, {16'h0, cexp}, 32'hffff, 1'b0);
        end
        // strapped control follows the mode pins
        sw <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            spm <= 2'(p);
            sxt <= p[0];
            per((p == 0) ? MR[2] : (p == 1) ? MR[1] : MR[0], 1);
            chk(cfg.clk_src === (p[0] ? CS_CRYSTAL : CS_CMOS), "src");
            chk(cfg.pmode === ((p == 3) ? PM_FAST : actree_pmode_e'(p)),
                "strap mode");
        end
        // mid-run reset clears the clocks and code
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk(data_clk === 1'b0 && res === 16'h0 && men === 8'h00,
            "reset state");
        reset_n_i <= 1'b1;
        // control register back at reset value, tree restarts on its own
        apb(1'b0, CTRL_OFFS, 32'h0, 32'h1ff, 1'b0);
        per(MR[0], 1);
        complete_run();
    end
endmodule : tb_top
